// ==== core/ufc_pkg.sv ====
// constants shared by the flow-control / infrared serial channel
// assumes a single clock domain (mclk) and synchronous inputs
package ufc_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  localparam int DIV_W = 16;
  localparam int FRAC_W = 4;
  localparam int LVL_W = 4;

  // modem_control_reg fields
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_SEL = 2;
  localparam int MCR_IR = 6;
  localparam int MCR_PRESC = 7;
  localparam logic [7:0] MCR_RST = 8'h00;

  // enhanced_feature_reg fields
  localparam int EFR_INT = 4;
  localparam int EFR_ARTS = 6;
  localparam int EFR_ACTS = 7;

  // interrupt_enable_reg / interrupt_status_reg fields, zero bits of divisor_fraction_rd
  localparam int IER_RTS = 6;
  localparam int IER_CTS = 7;
  localparam int ISR_FLOW = 5;
  localparam int FRAC_RD_ZERO = 4;

  // baud generator
  localparam logic [1:0] PRESC_LAST = 2'h3;
  localparam logic [DIV_W-1:0] DIV_MIN = 16'h0001;

  // samples per bit, infrared pulse width in samples, index of the last data bit
  localparam logic [4:0] OVS_16X = 5'h10;
  localparam logic [4:0] OVS_8X = 5'h08;
  localparam logic [4:0] IR_W_16X = 5'h03;
  localparam logic [4:0] IR_W_8X = 5'h02;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } ufc_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } ufc_rx_state_t;
endpackage : ufc_pkg

// ==== core/ufc_fifo.sv ====
// synchronous FIFO with valid/ready on both sides
// assumes depth is a power of two and matches the pointer width
module ufc_fifo #(
  parameter int W = 8,
  parameter int D = 8,
  parameter int AW = 3
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [AW:0] level
);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready = cnt_ff != (AW+1)'(D);
  assign out_valid = cnt_ff != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ff];
  assign level = cnt_ff;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule : ufc_fifo

// ==== core/ufc_baud_gen.sv ====
// prescaler and fractional baud divider giving a one-cycle sample tick
// assumes divisor and prescaler setting stay static while running
module ufc_baud_gen (
  input wire logic mclk,
  input wire logic reset,
  input wire logic presc_div4,
  input wire logic [ufc_pkg::DIV_W-1:0] divisor,
  input wire logic [ufc_pkg::FRAC_W-1:0] fraction,
  output logic tick
);
  logic [1:0] pre_ff;
  logic pre_en;
  logic [ufc_pkg::DIV_W-1:0] cnt_ff;
  logic [ufc_pkg::DIV_W-1:0] lim;
  logic [ufc_pkg::DIV_W-1:0] last;
  logic [ufc_pkg::FRAC_W-1:0] acc_ff;
  logic stretch_ff;
  logic tick_ff;
  logic [ufc_pkg::DIV_W+1:0] gap_ff;
  logic seen_ff;
  logic [ufc_pkg::DIV_W:0] cfg_ff;
  logic cfg_same;

  // a zero divisor would stall the channel, so it acts as one
  assign lim = (divisor == '0) ? ufc_pkg::DIV_MIN : divisor;
  assign last = stretch_ff ? lim : lim - ufc_pkg::DIV_MIN;
  assign pre_en = !presc_div4 || pre_ff == ufc_pkg::PRESC_LAST;
  assign tick = tick_ff;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  // a carry out of the sixteenths accumulator stretches the next period
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_ff <= '0;
      acc_ff <= '0;
      stretch_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (pre_en) begin
        if (cnt_ff >= last) begin
          cnt_ff <= '0;
          tick_ff <= 1'b1;
          {stretch_ff, acc_ff} <= {1'b0, acc_ff} + {1'b0, fraction};
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
  end

  // a new divisor or prescaler leaves one odd period, so the check rearms
  assign cfg_same = cfg_ff == {presc_div4, lim};

  always_ff @(posedge mclk) begin
    if (reset) begin
      gap_ff <= '0;
      seen_ff <= 1'b0;
      cfg_ff <= '0;
    end else begin
      cfg_ff <= {presc_div4, lim};
      seen_ff <= cfg_same && (seen_ff || tick_ff);
      if (tick_ff) begin
        gap_ff <= '0;
      end else begin
        gap_ff <= gap_ff + 1'b1;
      end
    end
  end

  property p_tick_period;
    @(posedge mclk) disable iff (reset)
    tick_ff && seen_ff && cfg_same && !presc_div4 |->
      gap_ff == {2'b00, lim} - 1'b1 || gap_ff == {2'b00, lim};
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("sample tick period not divisor or divisor+1");

  property p_presc;
    @(posedge mclk) disable iff (reset)
    pre_en && presc_div4 |=> (!pre_en || !presc_div4) [*3];
  endproperty
  a_presc: assert property (p_presc)
    else $error("prescaler enable closer than four cycles");
endmodule : ufc_baud_gen

// ==== core/ufc_flow_irda.sv ====
// one serial channel: fractional baud, auto handshake, infrared codec
// assumes synchronous inputs; configuration arrives as plain ports
module ufc_flow_irda (
  input wire logic mclk,
  input wire logic reset,
  input wire logic modem_control_wr,
  input wire logic [7:0] modem_control_wdata,
  output logic [7:0] modem_control_reg,
  input wire logic [7:0] enhanced_feature_reg,
  input wire logic [7:0] interrupt_enable_reg,
  input wire logic interrupt_status_rd,
  output logic [7:0] interrupt_status_reg,
  input wire logic [7:0] divisor_low_byte,
  input wire logic [7:0] divisor_high_byte,
  input wire logic [7:0] divisor_fraction,
  output logic [7:0] divisor_fraction_rd,
  input wire logic sample_8x,
  input wire logic ir_rx_invert,
  input wire logic [ufc_pkg::LVL_W-1:0] rx_trigger,
  input wire logic [ufc_pkg::LVL_W-1:0] rx_resume_level,
  input wire logic infrared_global_enable_pin,
  input wire logic [ufc_pkg::DATA_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [ufc_pkg::DATA_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [ufc_pkg::LVL_W-1:0] rx_level,
  output logic rx_overrun,
  output logic tx_busy,
  output logic ser_tx,
  input wire logic ser_rx,
  output logic rts_n,
  output logic dtr_n,
  input wire logic cts_n,
  input wire logic dsr_n
);
  logic tick;
  logic [4:0] ovs;
  logic [4:0] half;
  logic [4:0] irw;
  logic [7:0] mcr_ff;
  logic strap_ff;
  logic ir_mode;
  logic sel_dtr;
  logic auto_cts;
  logic auto_rts;
  logic hs_in_n;
  logic cts_stop;
  logic rx_go_ff;
  logic rts_act;
  logic dtr_act;
  logic hs_out_act;
  logic hs_in_prev_ff;
  logic hs_out_prev_ff;
  logic cts_ev;
  logic rts_ev;
  logic isr_flow_ff;
  logic txq_valid;
  logic txq_pop;
  logic [ufc_pkg::DATA_W-1:0] txq_data;
  ufc_pkg::ufc_tx_state_t tx_state_ff;
  logic [4:0] tx_cnt_ff;
  logic [2:0] tx_bit_ff;
  logic [ufc_pkg::DATA_W-1:0] tx_shift_ff;
  logic tx_line_ff;
  logic ser_tx_ff;
  logic ir_raw;
  logic [4:0] ir_hold_ff;
  logic rx_dec;
  logic rx_in;
  ufc_pkg::ufc_rx_state_t rx_state_ff;
  logic [4:0] rx_cnt_ff;
  logic [2:0] rx_bit_ff;
  logic [ufc_pkg::DATA_W-1:0] rx_shift_ff;
  logic rx_push_ff;
  logic rxq_ready;
  logic rx_overrun_ff;

  assign ovs = sample_8x ? ufc_pkg::OVS_8X : ufc_pkg::OVS_16X;
  assign irw = sample_8x ? ufc_pkg::IR_W_8X : ufc_pkg::IR_W_16X;
  assign half = ovs >> 1;

  ufc_baud_gen u_baud (
    .mclk(mclk),
    .reset(reset),
    .presc_div4(mcr_ff[ufc_pkg::MCR_PRESC]),
    .divisor({divisor_high_byte, divisor_low_byte}),
    .fraction(divisor_fraction[ufc_pkg::FRAC_W-1:0]),
    .tick(tick)
  );

  // upper fraction bits are not stored, so they read back zero
  assign divisor_fraction_rd = {{ufc_pkg::FRAC_RD_ZERO{1'b0}},
    divisor_fraction[ufc_pkg::FRAC_W-1:0]};

  // the pin is caught on the first edge after reset release
  always_ff @(posedge mclk) begin
    if (reset) begin
      strap_ff <= 1'b1;
    end else begin
      strap_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mcr_ff <= ufc_pkg::MCR_RST;
    end else if (modem_control_wr) begin
      mcr_ff <= modem_control_wdata;
    end else if (strap_ff) begin
      mcr_ff[ufc_pkg::MCR_IR] <= infrared_global_enable_pin;
    end
  end

  assign modem_control_reg = mcr_ff;
  assign ir_mode = mcr_ff[ufc_pkg::MCR_IR];
  assign sel_dtr = mcr_ff[ufc_pkg::MCR_SEL];
  assign auto_cts = enhanced_feature_reg[ufc_pkg::EFR_ACTS];
  assign auto_rts = enhanced_feature_reg[ufc_pkg::EFR_ARTS];
  assign hs_in_n = sel_dtr ? dsr_n : cts_n;
  assign cts_stop = auto_cts && hs_in_n;

  // receive gating with hysteresis between trigger and resume levels
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_go_ff <= 1'b1;
    end else if (rx_level >= rx_trigger) begin
      rx_go_ff <= 1'b0;
    end else if (rx_level <= rx_resume_level) begin
      rx_go_ff <= 1'b1;
    end
  end

  // software still owns the pin level; auto mode can only withdraw it
  assign rts_act = mcr_ff[ufc_pkg::MCR_RTS] &&
    (!(auto_rts && !sel_dtr) || rx_go_ff);
  assign dtr_act = mcr_ff[ufc_pkg::MCR_DTR] &&
    (!(auto_rts && sel_dtr) || rx_go_ff);
  assign rts_n = !rts_act;
  assign dtr_n = !dtr_act;
  assign hs_out_act = sel_dtr ? dtr_act : rts_act;

  always_ff @(posedge mclk) begin
    if (reset) begin
      hs_in_prev_ff <= 1'b1;
      hs_out_prev_ff <= 1'b0;
    end else begin
      hs_in_prev_ff <= hs_in_n;
      hs_out_prev_ff <= hs_out_act;
    end
  end

  assign cts_ev = hs_in_n && !hs_in_prev_ff && auto_cts &&
    enhanced_feature_reg[ufc_pkg::EFR_INT] &&
    interrupt_enable_reg[ufc_pkg::IER_CTS];
  assign rts_ev = !hs_out_act && hs_out_prev_ff &&
    enhanced_feature_reg[ufc_pkg::EFR_INT] &&
    interrupt_enable_reg[ufc_pkg::IER_RTS];

  // a new event in the clearing cycle keeps the flag set
  always_ff @(posedge mclk) begin
    if (reset) begin
      isr_flow_ff <= 1'b0;
    end else if (cts_ev || rts_ev) begin
      isr_flow_ff <= 1'b1;
    end else if (interrupt_status_rd) begin
      isr_flow_ff <= 1'b0;
    end
  end

  always_comb begin
    interrupt_status_reg = '0;
    interrupt_status_reg[ufc_pkg::ISR_FLOW] = isr_flow_ff;
  end

  ufc_fifo #(
    .W(ufc_pkg::DATA_W),
    .D(ufc_pkg::FIFO_DEPTH),
    .AW(ufc_pkg::FIFO_AW)
  ) u_txq (
    .mclk(mclk),
    .reset(reset),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(txq_valid),
    .out_ready(txq_pop),
    .out_data(txq_data),
    .level()
  );

  // a stop request only blocks the next start, never a running char
  assign txq_pop = tx_state_ff == ufc_pkg::TX_IDLE && !cts_stop;
  assign tx_busy = tx_state_ff != ufc_pkg::TX_IDLE;

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_state_ff <= ufc_pkg::TX_IDLE;
      tx_cnt_ff <= '0;
      tx_bit_ff <= '0;
      tx_shift_ff <= '0;
      tx_line_ff <= 1'b1;
    end else begin
      unique case (tx_state_ff)
        ufc_pkg::TX_IDLE: begin
          if (txq_valid && !cts_stop) begin
            tx_state_ff <= ufc_pkg::TX_START;
            tx_cnt_ff <= '0;
            tx_bit_ff <= '0;
            tx_shift_ff <= txq_data;
            tx_line_ff <= 1'b0;
          end
        end
        ufc_pkg::TX_START: begin
          if (tick && tx_cnt_ff == ovs - 1'b1) begin
            tx_cnt_ff <= '0;
            tx_state_ff <= ufc_pkg::TX_DATA;
            tx_line_ff <= tx_shift_ff[0];
          end else if (tick) begin
            tx_cnt_ff <= tx_cnt_ff + 1'b1;
          end
        end
        ufc_pkg::TX_DATA: begin
          if (tick && tx_cnt_ff == ovs - 1'b1) begin
            tx_cnt_ff <= '0;
            tx_shift_ff <= tx_shift_ff >> 1;
            if (tx_bit_ff == ufc_pkg::LAST_BIT) begin
              tx_state_ff <= ufc_pkg::TX_STOP;
              tx_line_ff <= 1'b1;
            end else begin
              tx_bit_ff <= tx_bit_ff + 1'b1;
              tx_line_ff <= tx_shift_ff[1];
            end
          end else if (tick) begin
            tx_cnt_ff <= tx_cnt_ff + 1'b1;
          end
        end
        ufc_pkg::TX_STOP: begin
          if (tick && tx_cnt_ff == ovs - 1'b1) begin
            tx_cnt_ff <= '0;
            tx_state_ff <= ufc_pkg::TX_IDLE;
          end else if (tick) begin
            tx_cnt_ff <= tx_cnt_ff + 1'b1;
          end
        end
      endcase
    end
  end

  // infrared: high only in the first samples of a zero bit
  always_ff @(posedge mclk) begin
    if (reset) begin
      ser_tx_ff <= 1'b1;
    end else if (ir_mode) begin
      ser_tx_ff <= !tx_line_ff && tx_busy && tx_cnt_ff < irw;
    end else begin
      ser_tx_ff <= tx_line_ff;
    end
  end
  assign ser_tx = ser_tx_ff;

  // decoder holds a zero for one bit period after each pulse
  assign ir_raw = ser_rx ^ ir_rx_invert;
  always_ff @(posedge mclk) begin
    if (reset) begin
      ir_hold_ff <= '0;
    end else if (!ir_mode) begin
      // a high line outside infrared mode must not leave a stale pulse
      ir_hold_ff <= '0;
    end else if (ir_raw) begin
      ir_hold_ff <= ovs;
    end else if (tick && ir_hold_ff != '0) begin
      ir_hold_ff <= ir_hold_ff - 1'b1;
    end
  end

  assign rx_dec = ir_mode ? (ir_hold_ff == '0 && !ir_raw) : ser_rx;
  assign rx_in = (ir_mode && tx_busy) ? 1'b1 : rx_dec;

  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_state_ff <= ufc_pkg::RX_IDLE;
      rx_cnt_ff <= '0;
      rx_bit_ff <= '0;
      rx_shift_ff <= '0;
      rx_push_ff <= 1'b0;
    end else begin
      rx_push_ff <= 1'b0;
      unique case (rx_state_ff)
        ufc_pkg::RX_IDLE: begin
          if (!rx_in) begin
            rx_state_ff <= ufc_pkg::RX_START;
            rx_cnt_ff <= '0;
          end
        end
        ufc_pkg::RX_START: begin
          if (tick && rx_cnt_ff == half - 1'b1) begin
            rx_cnt_ff <= '0;
            rx_bit_ff <= '0;
            rx_state_ff <= rx_in ? ufc_pkg::RX_IDLE : ufc_pkg::RX_DATA;
          end else if (tick) begin
            rx_cnt_ff <= rx_cnt_ff + 1'b1;
          end
        end
        ufc_pkg::RX_DATA: begin
          if (tick && rx_cnt_ff == ovs - 1'b1) begin
            rx_cnt_ff <= '0;
            rx_shift_ff <= {rx_in, rx_shift_ff[ufc_pkg::DATA_W-1:1]};
            rx_bit_ff <= rx_bit_ff + 1'b1;
            if (rx_bit_ff == ufc_pkg::LAST_BIT) begin
              rx_state_ff <= ufc_pkg::RX_STOP;
            end
          end else if (tick) begin
            rx_cnt_ff <= rx_cnt_ff + 1'b1;
          end
        end
        ufc_pkg::RX_STOP: begin
          // a missing stop bit drops the character
          if (tick && rx_cnt_ff == ovs - 1'b1) begin
            rx_cnt_ff <= '0;
            rx_push_ff <= rx_in;
            rx_state_ff <= ufc_pkg::RX_IDLE;
          end else if (tick) begin
            rx_cnt_ff <= rx_cnt_ff + 1'b1;
          end
        end
      endcase
    end
  end

  ufc_fifo #(
    .W(ufc_pkg::DATA_W),
    .D(ufc_pkg::FIFO_DEPTH),
    .AW(ufc_pkg::FIFO_AW)
  ) u_rxq (
    .mclk(mclk),
    .reset(reset),
    .in_valid(rx_push_ff),
    .in_ready(rxq_ready),
    .in_data(rx_shift_ff),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data),
    .level(rx_level)
  );

  // the line cannot be stalled, so a full queue loses the character
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_overrun_ff <= 1'b0;
    end else begin
      rx_overrun_ff <= rx_push_ff && !rxq_ready;
    end
  end
  assign rx_overrun = rx_overrun_ff;

  sequence s_release;
    $fell(reset) ##0 !modem_control_wr;
  endsequence

  property p_ir_strap;
    @(posedge mclk) s_release |=>
      mcr_ff[ufc_pkg::MCR_IR] == $past(infrared_global_enable_pin);
  endproperty
  a_ir_strap: assert property (p_ir_strap)
    else $error("infrared bit not loaded from global pin");

  property p_ir_write;
    @(posedge mclk) disable iff (reset)
    modem_control_wr |=>
      mcr_ff[ufc_pkg::MCR_IR] == $past(modem_control_wdata[ufc_pkg::MCR_IR]);
  endproperty
  a_ir_write: assert property (p_ir_write)
    else $error("software write did not set infrared bit");

  property p_ir_idle_low;
    @(posedge mclk) disable iff (reset)
    ir_mode && tx_state_ff == ufc_pkg::TX_IDLE |=> !ser_tx_ff;
  endproperty
  a_ir_idle_low: assert property (p_ir_idle_low)
    else $error("infrared transmit output not idle low");

  sequence s_zero_pulse;
    ir_mode && tx_busy && !tx_line_ff && tx_cnt_ff < irw;
  endsequence

  property p_ir_pulse;
    @(posedge mclk) disable iff (reset)
    s_zero_pulse |=> ser_tx_ff;
  endproperty
  a_ir_pulse: assert property (p_ir_pulse)
    else $error("infrared pulse missing for zero bit");

  property p_ir_one;
    @(posedge mclk) disable iff (reset)
    ir_mode && (tx_line_ff || tx_cnt_ff >= irw) |=> !ser_tx_ff;
  endproperty
  a_ir_one: assert property (p_ir_one)
    else $error("infrared pulse outside 3/16 window");

  property p_cts_hold;
    @(posedge mclk) disable iff (reset)
    cts_stop && tx_state_ff == ufc_pkg::TX_IDLE |=>
      tx_state_ff == ufc_pkg::TX_IDLE;
  endproperty
  a_cts_hold: assert property (p_cts_hold)
    else $error("character started while clear input de-asserted");

  property p_cts_irq;
    @(posedge mclk) disable iff (reset)
    $rose(hs_in_n) && auto_cts && enhanced_feature_reg[ufc_pkg::EFR_INT] &&
      interrupt_enable_reg[ufc_pkg::IER_CTS] |=> isr_flow_ff;
  endproperty
  a_cts_irq: assert property (p_cts_irq)
    else $error("clear input rise did not set status bit 5");

  property p_rts_irq;
    @(posedge mclk) disable iff (reset)
    $fell(hs_out_act) && enhanced_feature_reg[ufc_pkg::EFR_INT] &&
      interrupt_enable_reg[ufc_pkg::IER_RTS] |=> isr_flow_ff;
  endproperty
  a_rts_irq: assert property (p_rts_irq)
    else $error("request de-assert did not raise status");

  property p_rx_stop;
    @(posedge mclk) disable iff (reset)
    rx_level >= rx_trigger |=> !rx_go_ff ##0
      (!(auto_rts && !sel_dtr) || !rts_act);
  endproperty
  a_rx_stop: assert property (p_rx_stop)
    else $error("request not withdrawn at trigger level");

  property p_rx_hyst;
    @(posedge mclk) disable iff (reset)
    !rx_go_ff && rx_level > rx_resume_level |=> !rx_go_ff;
  endproperty
  a_rx_hyst: assert property (p_rx_hyst)
    else $error("request resumed above lower threshold");

  property p_echo_block;
    @(posedge mclk) disable iff (reset)
    ir_mode && tx_busy && rx_state_ff == ufc_pkg::RX_IDLE |=>
      rx_state_ff == ufc_pkg::RX_IDLE;
  endproperty
  a_echo_block: assert property (p_echo_block)
    else $error("receiver started during infrared transmit");
endmodule : ufc_flow_irda

// ==== sim/ufc_far_end.sv ====
// far-end partner: remote uart or infrared transceiver on the serial pins
// assumes one bit lasts BIT mclk cycles; drives 1 ns after rising edges
module ufc_far_end #(
  parameter int BIT = 16
) (
  input wire logic mclk,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got;
  int got_n = 0;
  initial line_out = 1'b1;
  task automatic rest(input logic v);
    line_out = v;
  endtask : rest
  // 8N1 frames; in infrared mode a 3-sample pulse stands for a zero bit
  task automatic send(input logic [7:0] d, input logic ir, input logic inv);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < BIT; c++) begin
        @(posedge mclk);
        #1;
        if (ir) line_out = inv ^ (!f[i] && c < 3);
        else line_out = f[i];
      end
    end
  endtask : send
  // receiver samples mid-bit; garbage while the channel transmits infrared
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge mclk);
      got[i] = line_in;
    end
    repeat (BIT) @(posedge mclk);
    got_n++;
  end
endmodule : ufc_far_end

// ==== sim/ufc_flow_irda_tb.sv ====
// self-checking bench for the flow-control / infrared serial channel
// assumes ufc_far_end on the pins; data traffic uses divisor 1, 16x
module ufc_flow_irda_tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
  logic mclk = 0, reset = 1, modem_control_wr = 0, interrupt_status_rd = 0;
  logic sample_8x = 0, ir_rx_invert = 0, infrared_global_enable_pin = 1;
  logic tx_valid = 0, rx_ready = 0, cts_n = 0, dsr_n = 0;
  logic [7:0] modem_control_wdata = 8'h00, enhanced_feature_reg = 8'h00;
  logic [7:0] interrupt_enable_reg = 8'h00, divisor_fraction = 8'h00;
  logic [7:0] divisor_low_byte = 8'h01, divisor_high_byte = 8'h00;
  logic [7:0] tx_data = 8'h00, rx_data;
  logic [3:0] rx_trigger = 4'h8, rx_resume_level = 4'h0, rx_level;
  logic [7:0] modem_control_reg, interrupt_status_reg, divisor_fraction_rd;
  logic tx_ready, rx_valid, rx_overrun, tx_busy, ser_tx, ser_rx, rts_n, dtr_n;
  int n_fail = 0, cmp_count = 0, n_ovr = 0;
  ufc_flow_irda i_dut (.mclk, .reset, .modem_control_wr, .modem_control_wdata,
    .modem_control_reg, .enhanced_feature_reg, .interrupt_enable_reg,
    .interrupt_status_rd, .interrupt_status_reg, .divisor_low_byte,
    .divisor_high_byte, .divisor_fraction, .divisor_fraction_rd, .sample_8x,
    .ir_rx_invert, .rx_trigger, .rx_resume_level, .infrared_global_enable_pin,
    .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .rx_level,
    .rx_overrun, .tx_busy, .ser_tx, .ser_rx, .rts_n, .dtr_n, .cts_n, .dsr_n);
  always @(posedge mclk) if (rx_overrun === 1'b1) n_ovr++;
  ufc_far_end #(.BIT(16)) i_far (.mclk(mclk), .line_in(ser_tx),
    .line_out(ser_rx));
  initial forever #10 mclk = ~mclk;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic mcr_wr(input logic [7:0] v);
    modem_control_wdata = v;
    modem_control_wr = 1;
    tick(1);
    modem_control_wr = 0;
  endtask : mcr_wr
  task automatic push(input logic [7:0] d);
    tx_data = d;
    tx_valid = 1;
    while (tx_ready !== 1'b1) tick(1);
    tick(1);
    tx_valid = 0;
    tick(1);
  endtask : push
  task automatic pop(input logic [7:0] e);
    for (int i = 0; i < 400 && rx_valid !== 1'b1; i++) tick(1);
    `CHK("rx_data", e, rx_data)
    rx_ready = 1;
    tick(1);
    rx_ready = 0;
  endtask : pop
  task automatic wait_got(input int n, input logic [7:0] e);
    for (int i = 0; i < 600 && i_far.got_n < n; i++) tick(1);
    `CHK("far_byte", e, i_far.got)
  endtask : wait_got
  // width of the first low data bit of 55h in mclk cycles for one baud setting
  task automatic t_baud(input logic [7:0] dl, input logic [7:0] fr,
                        input logic pre, input logic s8, input int e);
    int n;
    n = 0;
    divisor_low_byte = dl;
    divisor_fraction = fr;
    sample_8x = s8;
    mcr_wr({pre, 7'h00});
    // 55h gives a whole low data bit after the start bit, so the
    // partial first sample period stays out of the measurement
    push(8'h55);
    for (int i = 0; i < 100 && ser_tx !== 1'b0; i++) tick(1);
    for (int i = 0; i < 3000 && ser_tx !== 1'b1; i++) tick(1);
    for (int i = 0; i < 3000 && ser_tx !== 1'b0; i++) tick(1);
    while (ser_tx === 1'b0 && n < 3000) begin
      tick(1);
      n++;
    end
    `CHK("bit_cycles", e, n)
    for (int i = 0; i < 30000 && tx_busy !== 1'b0; i++) tick(1);
    tick(200);
  endtask : t_baud
  task automatic t_cts;
    int n0;
    n0 = i_far.got_n;
    enhanced_feature_reg = 8'h90;
    interrupt_enable_reg = 8'h80;
    push(8'hA1);
    push(8'hA2);
    tick(40);
    cts_n = 1;
    tick(3);
    `CHK("flow_irq", 1'b1, interrupt_status_reg[5])
    wait_got(n0 + 1, 8'hA1);
    tick(400);
    `CHK("held_count", n0 + 1, i_far.got_n)
    interrupt_status_rd = 1;
    tick(1);
    interrupt_status_rd = 0;
    tick(1);
    `CHK("irq_clear", 1'b0, interrupt_status_reg[5])
    cts_n = 0;
    wait_got(n0 + 2, 8'hA2);
    enhanced_feature_reg = 8'h80;
    tick(2);
    cts_n = 1;
    tick(3);
    `CHK("irq_gated", 1'b0, interrupt_status_reg[5])
    cts_n = 0;
    enhanced_feature_reg = 8'h00;
  endtask : t_cts
  task automatic t_rts;
    enhanced_feature_reg = 8'h50;
    interrupt_enable_reg = 8'h40;
    rx_trigger = 4'h2;
    rx_resume_level = 4'h1;
    mcr_wr(8'h02);
    `CHK("rts_on", 1'b0, rts_n)
    i_far.send(8'h11, 0, 0);
    i_far.send(8'h22, 0, 0);
    tick(4);
    `CHK("rx_level", 4'h2, rx_level)
    `CHK("rts_stop", 1'b1, rts_n)
    `CHK("rts_irq", 1'b1, interrupt_status_reg[5])
    pop(8'h11);
    tick(3);
    `CHK("rts_again", 1'b0, rts_n)
    pop(8'h22);
    for (int i = 0; i < 9; i++) i_far.send(8'(i), 1'b0, 1'b0);
    `CHK("overrun", 1, n_ovr)
    for (int i = 0; i < 8; i++) pop(8'(i));
    mcr_wr(8'h05);
    `CHK("dtr_sel", 2'b10, {rts_n, dtr_n})
    tick(1);
    mcr_wr(8'h00);
    enhanced_feature_reg = 8'h00;
    rx_trigger = 4'h8;
  endtask : t_rts
  task automatic t_ir;
    int hi, rises;
    logic prev;
    hi = 0;
    rises = 0;
    prev = 0;
    mcr_wr(8'h40);
    i_far.rest(0);
    tick(2);
    `CHK("ir_idle", 1'b0, ser_tx)
    push(8'hFE);
    for (int i = 0; i < 200; i++) begin
      if (i == 4) fork i_far.send(8'h5A, 1, 0); join_none
      tick(1);
      hi += ser_tx;
      rises += (ser_tx && !prev);
      prev = ser_tx;
    end
    `CHK("ir_hi", 6, hi)
    `CHK("ir_pulses", 2, rises)
    `CHK("echo", 4'h0, rx_level)
    i_far.send(8'h5A, 1, 0);
    pop(8'h5A);
    ir_rx_invert = 1;
    i_far.rest(1);
    tick(20);
    i_far.send(8'hC3, 1, 1);
    pop(8'hC3);
    ir_rx_invert = 0;
    i_far.rest(1);
    mcr_wr(8'h00);
    tick(200);
  endtask : t_ir
  task automatic give_verdict;
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    #1000000;
    n_fail++;
    give_verdict;
  end
  initial begin
    tick(16);
    reset = 0;
    tick(2);
    `CHK("mcr_pin", 8'h40, modem_control_reg)
    `CHK("idle_pins", 2'b01, {ser_tx, rts_n})
    infrared_global_enable_pin = 0;
    mcr_wr(8'h00);
    `CHK("mcr_wr", 8'h00, modem_control_reg)
    divisor_fraction = 8'hFF;
    tick(1);
    `CHK("frac_rd", 8'h0F, divisor_fraction_rd)
    t_baud(8'h01, 8'h00, 0, 0, 16);
    t_baud(8'h01, 8'h08, 0, 0, 24);
    t_baud(8'h01, 8'h00, 1, 0, 64);
    t_baud(8'h01, 8'h00, 0, 1, 8);
    t_baud(8'h9C, 8'h04, 0, 0, 2500);
    t_baud(8'h01, 8'h00, 0, 0, 16);
    push(8'hA5);
    push(8'h3C);
    wait_got(i_far.got_n + 1, 8'hA5);
    wait_got(i_far.got_n + 1, 8'h3C);
    t_cts;
    t_rts;
    t_ir;
    give_verdict;
  end
endmodule : ufc_flow_irda_tb
